// ===== dbg_sysreg_pkg.sv
// package: register selects, field positions, reset values and carriers for the sysreg block
package dbg_sysreg_pkg;

    // ****************************************
    // register selects
    // ****************************************
    typedef enum logic [2:0] {
        SEL_TC_PC,
        SEL_TC_STATUS,
        SEL_DBG_PC,
        SEL_DBG_STATUS,
        SEL_TC_BASE,
        SEL_DIR,
        SEL_NONE
    } reg_sel_t;

    // ****************************************
    // field layout
    // ****************************************
    localparam logic [31:0] PC_MASK = 32'h03FFFFFF;
    localparam logic [31:0] STATUS_MASK = 32'h000008FF;
    localparam logic [31:0] BASE_MASK = 32'h03FFFFFE;
    localparam logic [31:0] DIR_RESET = 32'h00000040;
    localparam logic [31:0] DIR_IMPL_MASK = 32'h00007F7F;
    localparam int SEQ_BIT = 14;
    localparam int WIN_BIT = 13;
    localparam int BANK_BIT = 12;
    localparam int JOINT_BIT = 11;
    localparam int MISALIGN_EN_BIT = 10;
    localparam int ALIGN_EN_BIT = 9;
    localparam int STEP_EN_BIT = 8;
    localparam int RST_MARK_BIT = 6;
    localparam int CH1_HIT_BIT = 5;
    localparam int CH0_HIT_BIT = 4;
    localparam int MON_ENTRY_BIT = 3;
    localparam int MISALIGN_HIT_BIT = 2;
    localparam int ALIGN_FAULT_BIT = 1;
    localparam int DEBUG_ACTIVE_BIT = 0;
    localparam int STEP_FLAG_BIT = 8;
    localparam logic [31:0] UNDEF_READ = 32'h00000000;

    // ****************************************
    // carriers
    // ****************************************
    typedef struct packed {
        logic table_call;
        logic exc_trap;
        logic dbg_trap;
        logic brk_exec;
        logic brk_misalign;
        logic brk_align;
        logic brk_access;
        logic single_step;
        logic [31:0] cur_pc;
        logic [31:0] next_pc;
        logic [31:0] status;
    } ctx_evt_t;

    typedef struct packed {
        logic func_reset;
        logic ch0_break;
        logic ch1_break;
        logic misalign_det;
        logic align_det;
        logic monitor_enter;
        logic monitor_return;
        logic debug_enter;
        logic user_enter;
    } dbg_evt_t;

    typedef struct packed {
        logic seq_mode;
        logic win_mode;
        logic bank_sel;
        logic joint_en;
        logic misalign_en;
        logic align_en;
        logic step_we;
        logic debug_active;
    } dbg_ctl_t;

endpackage : dbg_sysreg_pkg

// ===== dbg_sysreg.sv
// call and debug status save registers with the debug interface control register
`timescale 1ns/10ps

module dbg_sysreg (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // system register access
    input wire logic sr_load_i,
    input wire dbg_sysreg_pkg::reg_sel_t sr_sel_i,
    input wire logic [31:0] sr_wdata_i,
    output logic [31:0] sr_rdata_o,
    // context capture and debug events
    input wire dbg_sysreg_pkg::ctx_evt_t ctx_i,
    input wire dbg_sysreg_pkg::dbg_evt_t evt_i,
    // status step flag write path
    input wire logic step_flag_wr_i,
    input wire logic step_flag_val_i,
    output logic step_flag_o,
    // controls to the core
    output dbg_sysreg_pkg::dbg_ctl_t ctl_o,
    output logic [31:0] table_base_o
);
    import dbg_sysreg_pkg::*;

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] tc_pc_q, tc_pc_d;
    logic [31:0] tc_st_q, tc_st_d;
    logic [31:0] dbg_pc_q, dbg_pc_d;
    logic [31:0] dbg_st_q, dbg_st_d;
    logic [31:0] base_q, base_d;
    logic [31:0] dir_q, dir_d;
    logic [31:0] rdata_q, rdata_d;
    logic step_q, step_d;
    dbg_ctl_t ctl_q, ctl_d;

    // ****************************************
    // decode
    // ****************************************
    wire logic in_debug = dir_q[DEBUG_ACTIVE_BIT];
    wire logic wr_tc_pc = sr_load_i && (sr_sel_i == SEL_TC_PC);
    wire logic wr_tc_st = sr_load_i && (sr_sel_i == SEL_TC_STATUS);
    wire logic wr_dbg_pc = sr_load_i && (sr_sel_i == SEL_DBG_PC);
    wire logic wr_dbg_st = sr_load_i && (sr_sel_i == SEL_DBG_STATUS);
    wire logic wr_base = sr_load_i && (sr_sel_i == SEL_TC_BASE);
    wire logic wr_dir = sr_load_i && (sr_sel_i == SEL_DIR);
    wire logic wr_dir_dbg = wr_dir && in_debug;
    wire logic rst_mark = dir_q[RST_MARK_BIT];

    // save cause and pc selection
    wire logic dbg_save = ctx_i.exc_trap || ctx_i.dbg_trap || ctx_i.brk_exec
        || ctx_i.brk_misalign || ctx_i.brk_align || ctx_i.brk_access
        || ctx_i.single_step;
    wire logic save_own = ctx_i.brk_exec || ctx_i.brk_misalign
        || ctx_i.brk_align;
    // traps, access-trap breaks and steps all record the next pc
    wire logic [31:0] dbg_save_pc = save_own ? ctx_i.cur_pc : ctx_i.next_pc;

    // hardware capture wins over a concurrent software write
    assign tc_pc_d = (ctx_i.table_call ? ctx_i.next_pc
        : (wr_tc_pc ? sr_wdata_i : tc_pc_q)) & PC_MASK;
    assign tc_st_d = (ctx_i.table_call ? ctx_i.status
        : (wr_tc_st ? sr_wdata_i : tc_st_q)) & STATUS_MASK;
    assign dbg_pc_d = (dbg_save ? dbg_save_pc
        : (wr_dbg_pc ? sr_wdata_i : dbg_pc_q)) & PC_MASK;
    assign dbg_st_d = (dbg_save ? ctx_i.status
        : (wr_dbg_st ? sr_wdata_i : dbg_st_q)) & STATUS_MASK;
    assign base_d = (wr_base ? sr_wdata_i : base_q) & BASE_MASK;

    // ****************************************
    // debug interface control
    // ****************************************
    // software value per bit before hardware events are merged
    wire logic [31:0] w = sr_wdata_i;
    wire logic mark_next = evt_i.func_reset
        || (wr_dir_dbg ? w[RST_MARK_BIT] && rst_mark : rst_mark);
    // marker holds mode and bank cleared while set
    wire logic [2:0] mode_sw = wr_dir_dbg ? w[SEQ_BIT:BANK_BIT] : dir_q[SEQ_BIT:BANK_BIT];
    wire logic [2:0] mode_next = mark_next ? 3'h0 : mode_sw;
    wire logic [3:0] en_next = wr_dir_dbg ? w[JOINT_BIT:STEP_EN_BIT]
        : dir_q[JOINT_BIT:STEP_EN_BIT];
    // sticky flags, ch1 ch0 misalign align: software may only clear, set beats clear
    wire logic [3:0] flag_q = {dir_q[CH1_HIT_BIT], dir_q[CH0_HIT_BIT],
        dir_q[MISALIGN_HIT_BIT], dir_q[ALIGN_FAULT_BIT]};
    wire logic [3:0] flag_w = {w[CH1_HIT_BIT], w[CH0_HIT_BIT],
        w[MISALIGN_HIT_BIT], w[ALIGN_FAULT_BIT]};
    wire logic [3:0] flag_set = {evt_i.ch1_break, evt_i.ch0_break,
        evt_i.misalign_det && dir_q[MISALIGN_EN_BIT],
        evt_i.align_det && dir_q[ALIGN_EN_BIT]};
    // alignment fault flag is clearable in any mode
    wire logic [3:0] flag_wr = {wr_dir_dbg, wr_dir_dbg, wr_dir_dbg, wr_dir};
    // marker holds the channel hits at zero
    wire logic [3:0] flag_hold = {mark_next, mark_next, 1'b0, 1'b0};
    wire logic [3:0] flag_keep;
    wire logic [3:0] flag_next;
    for (genvar i = 0; i < 4; i++) begin : g_sticky
        assign flag_keep[i] = flag_wr[i] ? (flag_w[i] && flag_q[i]) : flag_q[i];
        assign flag_next[i] = !flag_hold[i] && (flag_set[i] || flag_keep[i]);
    end
    wire logic ch1_next = flag_next[3];
    wire logic ch0_next = flag_next[2];
    wire logic mis_next = flag_next[1];
    wire logic al_next = flag_next[0];
    // monitor entry and debug flags ignore software
    wire logic mon_next = evt_i.monitor_enter
        || (dir_q[MON_ENTRY_BIT] && !evt_i.monitor_return);
    wire logic dm_next = evt_i.debug_enter
        || (dir_q[DEBUG_ACTIVE_BIT] && !evt_i.user_enter);

    assign dir_d = {17'h00000, mode_next, en_next, 1'b0, mark_next, ch1_next, ch0_next,
        mon_next, mis_next, al_next, dm_next} & DIR_IMPL_MASK;

    // ****************************************
    // status step flag gating
    // ****************************************
    // step enable low pins the flag at zero regardless of writes
    assign step_d = dir_d[STEP_EN_BIT] && (step_flag_wr_i ? step_flag_val_i : step_q);

    // ****************************************
    // read path
    // ****************************************
    // user mode reads of debug-only fields return a fixed stand-in value
    wire logic [31:0] mon_view = 32'(dir_q[MON_ENTRY_BIT]) << MON_ENTRY_BIT;
    wire logic [31:0] dm_view = 32'(dir_q[DEBUG_ACTIVE_BIT]) << DEBUG_ACTIVE_BIT;
    wire logic [31:0] dir_user_view = mon_view | dm_view;
    always_comb begin
        rdata_d = 32'h00000000;
        unique case (sr_sel_i)
            SEL_TC_PC: rdata_d = tc_pc_q;
            SEL_TC_STATUS: rdata_d = tc_st_q;
            SEL_DBG_PC: rdata_d = in_debug ? dbg_pc_q : UNDEF_READ;
            SEL_DBG_STATUS: rdata_d = in_debug ? dbg_st_q : UNDEF_READ;
            SEL_TC_BASE: rdata_d = base_q;
            SEL_DIR: rdata_d = in_debug ? dir_q : dir_user_view;
            SEL_NONE: rdata_d = 32'h00000000;
            default: rdata_d = 32'h00000000;
        endcase
    end

    // ****************************************
    // control outputs
    // ****************************************
    // outputs are taken from the next register value, so they move on the same edge as the register
    // and a load is seen by the core right after the loading instruction retires
    always_comb begin
        ctl_d.seq_mode = dir_d[SEQ_BIT];
        ctl_d.win_mode = dir_d[WIN_BIT];
        ctl_d.bank_sel = dir_d[BANK_BIT];
        ctl_d.joint_en = dir_d[JOINT_BIT];
        ctl_d.misalign_en = dir_d[MISALIGN_EN_BIT];
        ctl_d.align_en = dir_d[ALIGN_EN_BIT];
        ctl_d.step_we = dir_d[STEP_EN_BIT];
        ctl_d.debug_active = dir_d[DEBUG_ACTIVE_BIT];
    end

    // ****************************************
    // table call return pc
    // ****************************************
    // zero at reset so the read path is always defined
    // a call in the same cycle as a load of this register wins
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tc_pc_q <= 32'h00000000;
        end else begin
            tc_pc_q <= tc_pc_d;
        end
    end

    // ****************************************
    // table call saved status
    // ****************************************
    // only the implemented status bits are stored
    // reserved positions are masked before the flop
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            tc_st_q <= 32'h00000000;
        end else begin
            tc_st_q <= tc_st_d;
        end
    end

    // ****************************************
    // debug return pc
    // ****************************************
    // writable in any mode; the read path hides it outside debug
    // a capture in the same cycle as a load wins
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dbg_pc_q <= 32'h00000000;
        end else begin
            dbg_pc_q <= dbg_pc_d;
        end
    end

    // ****************************************
    // debug saved status
    // ****************************************
    // same access rules as the debug return pc
    // reserved positions are masked before the flop
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dbg_st_q <= 32'h00000000;
        end else begin
            dbg_st_q <= dbg_st_d;
        end
    end

    // ****************************************
    // table call base pointer
    // ****************************************
    // bit 0 and the top bits never leave zero
    // the core sees the pointer straight from this flop
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            base_q <= 32'h00000000;
        end else begin
            base_q <= base_d;
        end
    end

    // ****************************************
    // debug interface control
    // ****************************************
    // reset leaves the marker set and the core in user mode
    // software must clear the marker, at the latest in the same write, for modes to be chosen
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            dir_q <= DIR_RESET;
        end else begin
            dir_q <= dir_d;
        end
    end

    // ****************************************
    // read data
    // ****************************************
    // read data lags the select by one edge
    // this keeps the output straight from a flop
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ****************************************
    // status step flag
    // ****************************************
    // the gate uses the next control value, so clearing the
    // enable drops the flag on the same edge
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            step_q <= 1'b0;
        end else begin
            step_q <= step_d;
        end
    end

    // ****************************************
    // control copy
    // ****************************************
    // a registered copy of the control fields for the core
    // it moves on the same edge as the control register
    always_ff @(posedge mclk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctl_q <= '0;
        end else begin
            ctl_q <= ctl_d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign sr_rdata_o = rdata_q;
    assign step_flag_o = step_q;
    assign ctl_o = ctl_q;
    assign table_base_o = base_q;

endmodule : dbg_sysreg

// ===== dbg_sysreg_checker.sv
// assertion checker for the call and debug save register block
`timescale 1ns/10ps
module dbg_sysreg_checker (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_n_i,
    // register access
    input wire logic sr_load_i,
    input wire dbg_sysreg_pkg::reg_sel_t sr_sel_i,
    input wire logic [31:0] sr_wdata_i,
    input wire logic [31:0] sr_rdata_o,
    // events and controls
    input wire dbg_sysreg_pkg::ctx_evt_t ctx_i,
    input wire dbg_sysreg_pkg::dbg_evt_t evt_i,
    input wire logic step_flag_wr_i,
    input wire logic step_flag_val_i,
    input wire logic step_flag_o,
    input wire dbg_sysreg_pkg::dbg_ctl_t ctl_o,
    input wire logic [31:0] table_base_o
);
    import dbg_sysreg_pkg::*;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!reset_n_i);
    chk_base_zero_bits: assert property ((table_base_o & ~BASE_MASK) == 32'h0)
        else $error("base pointer fixed bits set");
    chk_debug_flag_set: assert property (evt_i.debug_enter |=> ctl_o.debug_active)
        else $error("debug flag not set");
    chk_debug_flag_clear: assert property (evt_i.user_enter && !evt_i.debug_enter
        |=> !ctl_o.debug_active) else $error("debug flag not cleared");
    chk_step_flag_gate: assert property (!ctl_o.step_we |-> !step_flag_o)
        else $error("step flag set while gated");
    chk_user_write_drop: assert property (sr_load_i && sr_sel_i == SEL_DIR
        && !ctl_o.debug_active && !evt_i.func_reset && !evt_i.debug_enter
        |=> $stable(ctl_o[7:1])) else $error("control write took effect in user mode");
    chk_call_pc_save: assert property (ctx_i.table_call ##1 (sr_sel_i == SEL_TC_PC
        && !sr_load_i && !ctx_i.table_call) |=> sr_rdata_o == ($past(ctx_i.next_pc, 2)
        & PC_MASK)) else $error("table call return pc wrong");
    chk_user_dir_read: assert property (sr_sel_i == SEL_DIR && !ctl_o.debug_active
        |=> (sr_rdata_o & 32'hFFFFFFF6) == 32'h0) else $error("user control read leaks");
    chk_dir_reserved: assert property (sr_sel_i == SEL_DIR |=> sr_rdata_o[31:15] == '0
        && !sr_rdata_o[7]) else $error("control reserved bits set");
    chk_marker_clears: assert property (evt_i.func_reset |=> !ctl_o.seq_mode
        && !ctl_o.win_mode && !ctl_o.bank_sel) else $error("mode bits kept after reset");
    chk_user_dbg_read: assert property (sr_sel_i == SEL_DBG_PC && !ctl_o.debug_active
        |=> sr_rdata_o == UNDEF_READ) else $error("debug pc readable in user mode");
endmodule : dbg_sysreg_checker
bind dbg_sysreg dbg_sysreg_checker dbg_sysreg_checker_inst (.mclk_i, .reset_n_i, .sr_load_i,
    .sr_sel_i, .sr_wdata_i, .sr_rdata_o, .ctx_i, .evt_i, .step_flag_wr_i, .step_flag_val_i,
    .step_flag_o, .ctl_o, .table_base_o);

// ===== pipe_model.sv
// pipeline and monitor model that launches one-cycle context and debug event pulses
`timescale 1ns/10ps
module pipe_model (
    // clock
    input wire logic mclk_i,
    // event pulses toward the block
    output dbg_sysreg_pkg::ctx_evt_t ctx_o,
    output dbg_sysreg_pkg::dbg_evt_t evt_o
);
    import dbg_sysreg_pkg::*;
    initial begin
        ctx_o = '0;
        evt_o = '0;
    end
    // called at a falling edge, so exactly one rising edge sees the pulse
    task automatic fire(input ctx_evt_t c, input dbg_evt_t e);
        ctx_o = c;
        evt_o = e;
        @(negedge mclk_i);
        // stale context words are inverted so a late capture shows up
        ctx_o = {8'h00, ~c[95:0]};
        evt_o = '0;
    endtask : fire
endmodule : pipe_model

// ===== testbench.sv
// self-checking testbench for the call and debug save register block
`timescale 1ns/10ps
module testbench;
    import dbg_sysreg_pkg::*;
    logic mclk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic sr_load = 1'b0;
    reg_sel_t sel = SEL_NONE;
    logic [31:0] wd = 32'h0;
    logic [31:0] rdata;
    logic [31:0] tbase;
    logic sw = 1'b0;
    logic sv = 1'b0;
    logic sf;
    ctx_evt_t ctx;
    dbg_evt_t evt;
    dbg_ctl_t ctl;
    int failures = 0;
    int comparisons = 0;
    always #4 mclk_i = ~mclk_i;
    pipe_model pipe_model_inst (.mclk_i(mclk_i), .ctx_o(ctx), .evt_o(evt));
    dbg_sysreg dbg_sysreg_inst (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .sr_load_i(sr_load),
        .sr_sel_i(sel), .sr_wdata_i(wd), .sr_rdata_o(rdata), .ctx_i(ctx), .evt_i(evt),
        .step_flag_wr_i(sw), .step_flag_val_i(sv), .step_flag_o(sf), .ctl_o(ctl),
        .table_base_o(tbase));
    // ****************************************
    // shared tasks, entered at a falling edge except close_out on the timeout path, which is entered at a rising edge
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input reg_sel_t s, input logic [31:0] d);
        sr_load = 1'b1;
        sel = s;
        wd = d;
        @(negedge mclk_i);
        sr_load = 1'b0;
    endtask : wr
    task automatic rd(input reg_sel_t s, input logic [31:0] exp);
        sel = s;
        @(negedge mclk_i);
        chk(rdata, exp);
    endtask : rd
    task automatic ev(input dbg_evt_t e);
        pipe_model_inst.fire('0, e);
    endtask : ev
    task automatic close_out;
        if (failures == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_call_save;
        ctx_evt_t c = '0;
        c.table_call = 1'b1;
        c.next_pc = 32'hFFFFFFFF;
        c.status = 32'hFFFFFFFF;
        pipe_model_inst.fire(c, '0);
        rd(SEL_TC_PC, 32'h03FFFFFF);
        rd(SEL_TC_STATUS, 32'h000008FF);
    endtask : t_call_save
    task automatic t_dbg_save;
        ctx_evt_t c;
        rd(SEL_DBG_PC, UNDEF_READ);
        wr(SEL_DBG_PC, 32'hF1234567);
        ev(9'h002);
        rd(SEL_DBG_PC, 32'h01234567);
        // one pass per capture cause; exec, misalign and align breaks keep their own address
        for (int k = 0; k < 7; k++) begin
            c = '0;
            c[102:96] = 7'h40 >> k;
            c.cur_pc = 32'hFC001000 + k;
            c.next_pc = 32'hFC002000 + k;
            c.status = 32'hFFFFF7F0 | k;
            pipe_model_inst.fire(c, '0);
            rd(SEL_DBG_PC, (k inside {2, 3, 4}) ? 32'h1000 + k : 32'h2000 + k);
            rd(SEL_DBG_STATUS, 32'h0F0 | k);
        end
    endtask : t_dbg_save
    task automatic t_base;
        wr(SEL_TC_BASE, 32'hFFFFFFFF);
        chk(tbase, 32'h03FFFFFE);
        rd(SEL_TC_BASE, 32'h03FFFFFE);
    endtask : t_base
    task automatic t_dir_ctl;
        rd(SEL_DIR, 32'h00000041);
        wr(SEL_DIR, 32'h00003F7F);
        rd(SEL_DIR, 32'h00000F41);
        wr(SEL_DIR, 32'h00003F00);
        rd(SEL_DIR, 32'h00003F01);
        chk(32'(ctl), 32'h7F);
        sw = 1'b1;
        sv = 1'b1;
        @(negedge mclk_i);
        sw = 1'b0;
        chk(32'(sf), 32'h1);
        wr(SEL_DIR, 32'h00003E00);
        chk(32'(sf), 32'h0);
        chk(32'(ctl), 32'h7D);
    endtask : t_dir_ctl
    task automatic t_flags;
        ev(9'h0F8);
        rd(SEL_DIR, 32'h00003E3F);
        wr(SEL_DIR, 32'h00003E00);
        rd(SEL_DIR, 32'h00003E09);
        ev(9'h004);
        rd(SEL_DIR, 32'h00003E01);
        ev(9'h180);
        rd(SEL_DIR, 32'h00000E41);
    endtask : t_flags
    task automatic t_user;
        ev(9'h001);
        rd(SEL_DIR, 32'h00000000);
        wr(SEL_DIR, 32'hFFFFDFFF);
        ev(9'h002);
        rd(SEL_DIR, 32'h00000E41);
    endtask : t_user
    initial begin
        repeat (5000) @(posedge mclk_i);
        failures++;
        close_out();
    end
    initial begin
        repeat (10) @(negedge mclk_i);
        reset_n_i = 1'b1;
        rd(SEL_DIR, 32'h00000000);
        t_call_save();
        t_dbg_save();
        t_base();
        t_dir_ctl();
        t_flags();
        t_user();
        close_out();
    end
endmodule : testbench
